// ==== compliance_ctl_if.sv ====
// Carrier of the stored compliance fields from the register bank to the apply logic
`timescale 1ns/100ps
interface compliance_ctl_if;
   logic [2:0] margin;
   logic       mod_comp;
   logic       skip;
   logic       deemph;

   modport src (output margin, output mod_comp, output skip, output deemph);
   modport dst (input margin, input mod_comp, input skip, input deemph);
endinterface

// ==== lcm_pkg.sv ====
// Constants, field layout and types shared by the compliance margin control block
package lcm_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [31:0] LINK_CTL_TWO_ADDR = 32'h0000_0070;
   localparam int          WORD_LSB          = 2;

   // ------------------------------------------------------------------
   // Field positions inside link_control_two
   // ------------------------------------------------------------------
   localparam int TS_LSB  = 0;
   localparam int TS_MSB  = 3;
   localparam int FC_BIT  = 4;
   localparam int TM_LSB  = 7;
   localparam int TM_MSB  = 9;
   localparam int MC_BIT  = 10;
   localparam int SK_BIT  = 11;
   localparam int DE_BIT  = 12;
   localparam int RSV_LSB = 13;
   localparam int RSV_MSB = 15;

   // ------------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [3:0] TS_RESET     = 4'h2;
   localparam logic [3:0] TS_GEN1      = 4'h1;
   localparam logic [3:0] TS_GEN2      = 4'h2;
   localparam logic [2:0] TM_NORMAL    = 3'h0;
   localparam logic [2:0] TM_MAX_LEGAL = 3'h5;
   localparam logic       DEEMPH_6DB   = 1'h0;
   localparam logic       DEEMPH_3P5DB = 1'h1;

   // ------------------------------------------------------------------
   // AHB-Lite encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // Data phase tracker of the bus slave
   typedef enum logic [1:0] {
      DP_IDLE  = 2'b00,
      DP_WRITE = 2'b01,
      DP_READ  = 2'b10
   } dphase_t;

endpackage

// ==== link_compliance_margin_ctl.sv ====
// Link control two register bank on AHB-Lite with the compliance and margin debug fields
`timescale 1ns/100ps

// Functional notes
// R1 - Margin codes 0..5 legal, 6,7 reserved
// R2 - Entering polling configuration clears margin field
// R3 - Normal margin code selects per-lane drive registers
// R4 - New margin applied only at receiver lock
// R5 - Software should retrain after changing margin
// R6 - Software touches debug fields only when testing
// R7 - Modified bit selects modified compliance pattern
// R8 - Skip bit inserts skip sets during compliance
// R9 - De-emphasis bit used only in forced compliance
// R10 - De-emphasis zero is -6 dB, one -3.5
// R11 - Force compliance bit plus hot reset
// R12 - Target speed 1 is gen1, 2 gen2
// R13 - Sticky fields zero at power-up, 15:13 zero; target speed powers up as TS_RESET, 2
module link_compliance_margin_ctl (
   input  logic        CLOCK,
   input  logic        RST_N,
   input  logic        HSEL,
   input  logic [31:0] HADDR,
   input  logic [1:0]  HTRANS,
   input  logic        HWRITE,
   input  logic [2:0]  HSIZE,
   input  logic [31:0] HWDATA,
   input  logic        HREADY,
   output logic        HREADYOUT,
   output logic        HRESP,
   output logic [31:0] HRDATA,
   input  logic        LTSSM_POLL_CFG_ENTRY,
   input  logic        LTSSM_RCVR_LOCK,
   input  logic        LTSSM_POLL_COMPLIANCE,
   input  logic        COMPLIANCE_BY_FORCE,
   output logic [2:0]  TX_MARGIN_LEVEL,
   output logic        TX_LEVEL_FROM_LANE_REGS,
   output logic        TX_MODIFIED_COMPLIANCE,
   output logic        SKIP_INSERT_EN,
   output logic        COMPLIANCE_DEEMPH_OVERRIDE,
   output logic        COMPLIANCE_DEEMPH,
   output logic        FORCE_COMPLIANCE,
   output logic [3:0]  TARGET_SPEED
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      lcm_pkg::dphase_t phase;
      logic [31:0]      addr;
      logic [31:0]      rdata;
      logic [3:0]       target_speed;
      logic             force_compliance;
      logic [2:0]       tx_margin_level;
      logic             modified_compliance_req;
      logic             compliance_skip_insert;
      logic             compliance_deemph_sel;
   } bank_state_t;

   bank_state_t cur;
   bank_state_t next_cur;

   compliance_ctl_if ctl_bus ();

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Word-aligned decode; low address bits are ignored as only whole words are used
   function automatic logic addr_hit(input logic [31:0] a);
      addr_hit = (a[31:lcm_pkg::WORD_LSB] == lcm_pkg::LINK_CTL_TWO_ADDR[31:lcm_pkg::WORD_LSB]);
   endfunction

   // Register image; reserved and upper bits read as zero
   function automatic logic [31:0] reg_image(input bank_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[lcm_pkg::TS_MSB:lcm_pkg::TS_LSB] = s.target_speed;
      w[lcm_pkg::FC_BIT]                 = s.force_compliance;
      w[lcm_pkg::TM_MSB:lcm_pkg::TM_LSB] = s.tx_margin_level;
      w[lcm_pkg::MC_BIT]                 = s.modified_compliance_req;
      w[lcm_pkg::SK_BIT]                 = s.compliance_skip_insert;
      w[lcm_pkg::DE_BIT]                 = s.compliance_deemph_sel;
      reg_image = w;
   endfunction

   logic       wr_hit;
   logic [2:0] wr_margin;
   logic       addr_take;

   // Decode of the data-phase write and the address phase
   assign wr_hit    = (cur.phase == lcm_pkg::DP_WRITE) && addr_hit(cur.addr);
   assign wr_margin = HWDATA[lcm_pkg::TM_MSB:lcm_pkg::TM_LSB];
   assign addr_take = HSEL && HREADY && (HTRANS == lcm_pkg::HTRANS_NONSEQ);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Hardware clear on polling entry is applied after the write so it wins the cycle
   always_comb begin
      next_cur = cur;
      if (wr_hit) begin
         next_cur.target_speed            = HWDATA[lcm_pkg::TS_MSB:lcm_pkg::TS_LSB]; // R12
         next_cur.force_compliance        = HWDATA[lcm_pkg::FC_BIT]; // R11
         next_cur.modified_compliance_req = HWDATA[lcm_pkg::MC_BIT];
         next_cur.compliance_skip_insert  = HWDATA[lcm_pkg::SK_BIT];
         next_cur.compliance_deemph_sel   = HWDATA[lcm_pkg::DE_BIT];
         // Reserved codes are dropped so the transmitter never sees an undefined swing
         if (wr_margin <= lcm_pkg::TM_MAX_LEGAL) begin
            next_cur.tx_margin_level = wr_margin; // R1
         end
      end
      if (LTSSM_POLL_CFG_ENTRY) begin
         next_cur.tx_margin_level = lcm_pkg::TM_NORMAL; // R2
      end
      if (addr_take) begin
         next_cur.addr  = HADDR;
         next_cur.phase = HWRITE ? lcm_pkg::DP_WRITE : lcm_pkg::DP_READ;
         // Image taken from next state so a read right after a write sees the new value
         if (!HWRITE) begin
            next_cur.rdata = addr_hit(HADDR) ? reg_image(next_cur) : 32'h0000_0000;
         end
      end else begin
         next_cur.phase = lcm_pkg::DP_IDLE;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   // Only power-up reset reaches here; hot and link resets leave the fields alone
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         cur <= '{phase: lcm_pkg::DP_IDLE, addr: 32'h0000_0000, rdata: 32'h0000_0000,
                  target_speed: lcm_pkg::TS_RESET, force_compliance: 1'h0,
                  tx_margin_level: lcm_pkg::TM_NORMAL, modified_compliance_req: 1'h0,
                  compliance_skip_insert: 1'h0, compliance_deemph_sel: 1'h0}; // R13
      end else begin
         cur <= next_cur;
      end
   end

   // ------------------------------------------------------------------
   // Bus answer and field outputs
   // ------------------------------------------------------------------
   // Zero-wait slave, always OKAY
   assign HREADYOUT        = 1'h1;
   assign HRESP            = lcm_pkg::HRESP_OKAY;
   assign HRDATA           = cur.rdata;
   assign FORCE_COMPLIANCE = cur.force_compliance;
   assign TARGET_SPEED     = cur.target_speed;

   // Stored fields to the apply logic
   assign ctl_bus.margin   = cur.tx_margin_level;
   assign ctl_bus.mod_comp = cur.modified_compliance_req;
   assign ctl_bus.skip     = cur.compliance_skip_insert;
   assign ctl_bus.deemph   = cur.compliance_deemph_sel;

   // ------------------------------------------------------------------
   // Transmitter side
   // ------------------------------------------------------------------
   margin_apply u_apply (
      .clock             (CLOCK),
      .rst_n             (RST_N),
      .ctl               (ctl_bus.dst),
      .poll_cfg_entry    (LTSSM_POLL_CFG_ENTRY),
      .rcvr_lock         (LTSSM_RCVR_LOCK),
      .poll_compliance   (LTSSM_POLL_COMPLIANCE),
      .by_force          (COMPLIANCE_BY_FORCE),
      .tx_margin         (TX_MARGIN_LEVEL),
      .from_lane_regs    (TX_LEVEL_FROM_LANE_REGS),
      .tx_mod_compliance (TX_MODIFIED_COMPLIANCE),
      .skip_insert_en    (SKIP_INSERT_EN),
      .deemph_override   (COMPLIANCE_DEEMPH_OVERRIDE),
      .deemph            (COMPLIANCE_DEEMPH)
   );

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_field_legal: assert property (cur.tx_margin_level <= lcm_pkg::TM_MAX_LEGAL) // R1
      else $error("reserved margin code stored");
   a_reserved_drop: assert property (wr_hit && wr_margin > lcm_pkg::TM_MAX_LEGAL && !LTSSM_POLL_CFG_ENTRY
                                     |=> $stable(cur.tx_margin_level)) // R1
      else $error("reserved margin write accepted");
   a_field_clear: assert property (LTSSM_POLL_CFG_ENTRY |=> cur.tx_margin_level == lcm_pkg::TM_NORMAL) // R2
      else $error("margin field not cleared");
   a_margin_write: assert property (wr_hit && wr_margin <= lcm_pkg::TM_MAX_LEGAL && !LTSSM_POLL_CFG_ENTRY
                                    |=> cur.tx_margin_level == $past(wr_margin)) // R1
      else $error("margin write lost");
   a_mod_write: assert property (wr_hit |=> cur.modified_compliance_req == $past(HWDATA[lcm_pkg::MC_BIT])) // R7
      else $error("modified bit write lost");
   a_skip_write: assert property (wr_hit |=> cur.compliance_skip_insert == $past(HWDATA[lcm_pkg::SK_BIT])) // R8
      else $error("skip bit write lost");
   a_speed_write: assert property (wr_hit |=> TARGET_SPEED == $past(HWDATA[lcm_pkg::TS_MSB:lcm_pkg::TS_LSB])) // R12
      else $error("target speed write lost");
   a_force_write: assert property (wr_hit |=> FORCE_COMPLIANCE == $past(HWDATA[lcm_pkg::FC_BIT])) // R11
      else $error("force bit write lost");
   a_upper_zero: assert property (cur.phase == lcm_pkg::DP_READ |-> HRDATA[31:lcm_pkg::RSV_LSB] == 19'h0_0000) // R13
      else $error("reserved bits read nonzero");
   a_read_back: assert property (addr_take && !HWRITE && addr_hit(HADDR) && !wr_hit && !LTSSM_POLL_CFG_ENTRY
                                 |=> HRDATA[lcm_pkg::DE_BIT] == $past(cur.compliance_deemph_sel)) // R10
      else $error("read data mismatch");
   a_unmapped_zero: assert property (addr_take && !HWRITE && !addr_hit(HADDR) |=> HRDATA == 32'h0000_0000)
      else $error("unmapped read nonzero");

   c_margin_set: cover property (wr_hit && wr_margin != lcm_pkg::TM_NORMAL ##[1:20] LTSSM_RCVR_LOCK);
   c_clear_race: cover property (wr_hit && LTSSM_POLL_CFG_ENTRY);

endmodule

// ==== link_compliance_margin_ctl_tb.sv ====
// Self-checking bench for the link control two register bank and its compliance outputs
`timescale 1ns/100ps
module link_compliance_margin_ctl_tb;
   localparam logic [31:0] A = lcm_pkg::LINK_CTL_TWO_ADDR;
   logic        CLOCK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
   logic [31:0] HADDR, HWDATA, HRDATA;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE, TX_MARGIN_LEVEL, cur;
   logic        poll_cfg, lock, comp, by_force, go_cfg, go_lock, go_comp, hot_reset;
   logic        from_lane, mod_comp, skip_en, de_ovr, deemph, force_comp;
   logic [3:0]  TARGET_SPEED;
   int          n_fail, n_tests;

   link_compliance_margin_ctl DUT (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .HRDATA(HRDATA), .LTSSM_POLL_CFG_ENTRY(poll_cfg), .LTSSM_RCVR_LOCK(lock),
      .LTSSM_POLL_COMPLIANCE(comp), .COMPLIANCE_BY_FORCE(by_force), .TX_MARGIN_LEVEL(TX_MARGIN_LEVEL),
      .TX_LEVEL_FROM_LANE_REGS(from_lane), .TX_MODIFIED_COMPLIANCE(mod_comp), .SKIP_INSERT_EN(skip_en),
      .COMPLIANCE_DEEMPH_OVERRIDE(de_ovr), .COMPLIANCE_DEEMPH(deemph), .FORCE_COMPLIANCE(force_comp),
      .TARGET_SPEED(TARGET_SPEED));

   ltssm_model link (.clock(CLOCK), .rst_n(RST_N), .go_cfg(go_cfg), .go_lock(go_lock), .go_comp(go_comp),
      .hot_reset(hot_reset), .force_seen(force_comp), .poll_cfg_entry(poll_cfg), .rcvr_lock(lock),
      .poll_compliance(comp), .by_force(by_force));

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   // Single exit point of the run
   task automatic give_verdict;
      if (n_fail == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Compare and report; narrower outputs are zero extended so an unknown still mismatches
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait for hready at a rising edge
   task automatic wait_ready;
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge CLOCK);
         if (HREADYOUT === 1'h1) break;
      end
      if (i >= 50) begin
         n_fail++;
         give_verdict();
      end
   endtask

   // One single AHB-Lite transfer: address phase held to hready, then data phase held to hready
   task automatic ahb(input logic is_wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rdata);
      @(posedge CLOCK);
      HSEL   <= 1'h1;
      HADDR  <= addr;
      HTRANS <= lcm_pkg::HTRANS_NONSEQ;
      HWRITE <= is_wr;
      HSIZE  <= 3'h2;
      wait_ready();
      HTRANS <= 2'h0;
      HWDATA <= is_wr ? wd : ~wd;
      wait_ready();
      rdata = HRDATA;
      check(32'(HRESP), 32'(lcm_pkg::HRESP_OKAY));
      HSEL   <= 1'h0;
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'h1, addr, d, r);
   endtask

   task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
      logic [31:0] r;
      ahb(1'h0, addr, 32'h0, r);
      check(r, exp);
   endtask

   // Model lag plus design lag, then step off the edge
   task automatic settle;
      repeat (3) @(posedge CLOCK);
      #1;
   endtask

   // Retrain: one pass through receiver lock
   task automatic lock_pulse;
      @(posedge CLOCK);
      go_lock <= 1'h1;
      @(posedge CLOCK);
      go_lock <= 1'h0;
      settle();
   endtask

   // ------------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------------
   initial begin
      CLOCK = 1'h0;
      forever #4 CLOCK = ~CLOCK;
   end

   // A hang counts as a mismatch and still reaches the verdict
   initial begin
      repeat (20000) @(posedge CLOCK);
      n_fail++;
      give_verdict();
   end

   initial begin
      {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
      {go_cfg, go_lock, go_comp, hot_reset} = '0;
      HSIZE = 3'h2;
      RST_N = 1'h0;
      n_fail = 0;
      n_tests = 0;
      repeat (4) @(posedge CLOCK);
      RST_N <= 1'h1;
      #1;
      check(32'(TARGET_SPEED), 32'(lcm_pkg::TS_RESET));
      check(32'(from_lane), 32'h1);
      check(32'(TX_MARGIN_LEVEL), 32'h0);
      rd(A, 32'(lcm_pkg::TS_RESET));
      rd(A + 32'h4, 32'h0);
      // Reserved and out-of-scope bits written as ones must read back zero
      wr(A, 32'hFFFF_FDF1);
      rd(A, 32'h0000_1D91);
      check(32'(TARGET_SPEED), 32'(lcm_pkg::TS_GEN1));
      check(32'(force_comp), 32'h1);
      check(32'(TX_MARGIN_LEVEL), 32'h0);
      lock_pulse();
      check(32'(TX_MARGIN_LEVEL), 32'h3);
      check(32'(from_lane), 32'h0);
      // Every margin code; reserved codes leave the field alone
      cur = 3'h3;
      for (int m = 0; m < 8; m++) begin
         wr(A, 32'h1C11 | (32'(m) << lcm_pkg::TM_LSB));
         if (m <= 5) cur = 3'(m);
         rd(A, 32'h1C11 | (32'(cur) << lcm_pkg::TM_LSB));
         lock_pulse();
         check(32'(TX_MARGIN_LEVEL), 32'(cur));
         check(32'(from_lane), 32'(cur == 3'h0));
      end
      // Polling configuration entry clears field and applied level
      @(posedge CLOCK);
      go_cfg <= 1'h1;
      @(posedge CLOCK);
      go_cfg <= 1'h0;
      settle();
      check(32'(TX_MARGIN_LEVEL), 32'h0);
      check(32'(from_lane), 32'h1);
      rd(A, 32'h1C11);
      // Compliance entered normally: de-emphasis bit must not apply
      @(posedge CLOCK);
      go_comp <= 1'h1;
      settle();
      check(32'(mod_comp), 32'h1);
      check(32'(skip_en), 32'h1);
      check(32'(de_ovr), 32'h0);
      check(32'(deemph), 32'(lcm_pkg::DEEMPH_6DB));
      // Forced entry through hot reset with the force bit set
      @(posedge CLOCK);
      hot_reset <= 1'h1;
      @(posedge CLOCK);
      hot_reset <= 1'h0;
      settle();
      check(32'(de_ovr), 32'h1);
      check(32'(deemph), 32'(lcm_pkg::DEEMPH_3P5DB));
      wr(A, 32'h0000_0011);
      settle();
      check(32'(deemph), 32'(lcm_pkg::DEEMPH_6DB));
      check(32'(mod_comp), 32'h0);
      check(32'(skip_en), 32'h0);
      @(posedge CLOCK);
      go_comp <= 1'h0;
      settle();
      check(32'(de_ovr), 32'h0);
      // Sticky fields are cleared only by the power-up reset
      wr(A, 32'h0000_1D91);
      rd(A, 32'h0000_1D91);
      @(posedge CLOCK);
      RST_N <= 1'h0;
      @(posedge CLOCK);
      RST_N <= 1'h1;
      rd(A, 32'(lcm_pkg::TS_RESET));
      wr(A, 32'(lcm_pkg::TS_RESET));
      rd(A, 32'(lcm_pkg::TS_RESET));
      give_verdict();
   end
endmodule

// ==== ltssm_model.sv ====
// Behavioural stand-in for the training state machine that drives the link-side milestones
`timescale 1ns/100ps
module ltssm_model (
   input  logic clock,
   input  logic rst_n,
   input  logic go_cfg,
   input  logic go_lock,
   input  logic go_comp,
   input  logic hot_reset,
   input  logic force_seen,
   output logic poll_cfg_entry,
   output logic rcvr_lock,
   output logic poll_compliance,
   output logic by_force
);
   // ------------------------------------------------------------------
   // State walk
   // ------------------------------------------------------------------
   // Forced entry needs the force bit plus a hot reset; leaving compliance drops the reason
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         poll_cfg_entry  <= 1'h0;
         rcvr_lock       <= 1'h0;
         poll_compliance <= 1'h0;
         by_force        <= 1'h0;
      end else begin
         poll_cfg_entry  <= go_cfg;
         rcvr_lock       <= go_lock;
         poll_compliance <= go_comp;
         by_force        <= go_comp & (by_force | (hot_reset & force_seen));
      end
   end
endmodule

// ==== margin_apply.sv ====
// Applies the stored margin and compliance fields to the transmitter at LTSSM milestones
`timescale 1ns/100ps
module margin_apply (
   input  logic                  clock,
   input  logic                  rst_n,
   compliance_ctl_if.dst         ctl,
   input  logic                  poll_cfg_entry,
   input  logic                  rcvr_lock,
   input  logic                  poll_compliance,
   input  logic                  by_force,
   output logic [2:0]            tx_margin,
   output logic                  from_lane_regs,
   output logic                  tx_mod_compliance,
   output logic                  skip_insert_en,
   output logic                  deemph_override,
   output logic                  deemph
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0] applied;
      logic       from_lane;
      logic       tx_mod;
      logic       skip_en;
      logic       ovr;
      logic       deemph;
   } app_state_t;

   app_state_t cur;
   app_state_t next_cur;

   // Margin only moves in the LTSSM window, so a mid-link write never glitches the swing
   always_comb begin
      next_cur = cur;
      if (poll_cfg_entry) begin
         next_cur.applied = lcm_pkg::TM_NORMAL; // R2
      end else if (rcvr_lock) begin
         next_cur.applied = ctl.margin; // R4
      end
      next_cur.from_lane = (next_cur.applied == lcm_pkg::TM_NORMAL); // R3
      next_cur.tx_mod    = poll_compliance & ctl.mod_comp; // R7
      next_cur.skip_en   = poll_compliance & ctl.skip; // R8
      next_cur.ovr       = poll_compliance & by_force; // R9
      next_cur.deemph    = (poll_compliance & by_force) ? ctl.deemph : lcm_pkg::DEEMPH_6DB; // R10
   end

   // Applied state is not sticky: it follows the link, only the register bank is
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '{applied: lcm_pkg::TM_NORMAL, from_lane: 1'h1, tx_mod: 1'h0, skip_en: 1'h0, ovr: 1'h0,
                  deemph: lcm_pkg::DEEMPH_6DB};
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from flip-flops
   assign tx_margin         = cur.applied;
   assign from_lane_regs    = cur.from_lane;
   assign tx_mod_compliance = cur.tx_mod;
   assign skip_insert_en    = cur.skip_en;
   assign deemph_override   = cur.ovr;
   assign deemph            = cur.deemph;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_apply_in_window: assert property (rcvr_lock && !poll_cfg_entry |=> tx_margin == $past(ctl.margin)) // R4
      else $error("margin not applied in window");
   a_hold_outside: assert property (!rcvr_lock && !poll_cfg_entry |=> $stable(tx_margin)) // R4
      else $error("margin changed outside window");
   a_entry_clears: assert property (poll_cfg_entry |=> tx_margin == lcm_pkg::TM_NORMAL) // R2
      else $error("applied margin not cleared");
   a_lane_source: assert property (from_lane_regs == (tx_margin == lcm_pkg::TM_NORMAL)) // R3
      else $error("drive source mismatch");
   a_mod_pattern: assert property (poll_compliance && ctl.mod_comp |=> tx_mod_compliance) // R7
      else $error("modified pattern not selected");
   a_skip_gate: assert property (skip_insert_en |-> $past(poll_compliance) && $past(ctl.skip)) // R8
      else $error("skip insertion without request");
   a_deemph_force: assert property (deemph_override |-> $past(by_force)) // R9
      else $error("override without forced entry");
   a_deemph_value: assert property (deemph_override |-> deemph == $past(ctl.deemph)) // R10
      else $error("wrong compliance de-emphasis");

   c_apply: cover property (rcvr_lock ##1 tx_margin != lcm_pkg::TM_NORMAL);
   c_mod: cover property (tx_mod_compliance && skip_insert_en);
   c_ovr: cover property (deemph_override && deemph == lcm_pkg::DEEMPH_3P5DB);

endmodule
